// file: sysc_device.sv
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// - probe limit field, reset 1, zero means eight
// - request credit field, reset 2, never 1
// - transfer credit field, reset 1, first rev <=2
// - advertised fill limit, match bridge, first rev <=4
// - true fill limit equals bridge queue limit
// - bit 39 disables memory xor
// - pad queue limit: 4 two slices, else 8
// - bits 35..33 disable bypass paths 3..1
// - probe limit 1 needs forced throttle set
// - bit 31 inserts one extract-fill dead cycle
// - drain interval codes 1..5, zero disables
// - fill-extract turnaround 1..3 cycles, delay constraint
// - bits 61,60 report wide io buses
// - extract delay codes 0..3 mean 2..5 cycles
module sysc_device (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // avalon-mm slave
    input  wire logic [1:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWritedata,
    input  wire logic [3:0]  avsByteenable,
    output logic [31:0]      avsReaddata,
    output logic             avsWaitrequest,
    // link to far end
    sysc_if.device           lnk,
    // decoded controls toward the core
    output logic             memXorDisable,
    output logic [2:0]       bypassDisable
);
    logic [63:0] cfg_reg;
    logic [63:0] cfg_next;
    logic [31:0] rdata_reg;
    logic        ack_reg;
    logic        wait_reg;
    logic [63:0] wideBits;
    logic [10:0] drainCnt_reg;
    logic        drain_reg;
    logic [3:0]  probe_reg;
    logic [2:0]  xdly_reg;
    logic        xor_reg;
    logic [2:0]  byp_reg;
    logic [63:0] wmask;
    logic [63:0] wdata64;
    logic [10:0] drainLen;
    logic [2:0]  drainCode;
    logic [2:0]  probeField;
    logic [63:0] readWord;
    logic        doWrite;
    logic        doRead;

    // one wait cycle per access; a write lands on the answering edge only
    assign doWrite = avsWrite && ack_reg;
    assign doRead  = avsRead && !ack_reg;

    // byte lanes placed into the half selected by address
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : gLane
            assign wmask[8*b+7:8*b]    = {8{avsByteenable[b] &&
                                           avsAddress == sysc_pkg::ADDR_LO}};
            assign wmask[8*b+39:8*b+32] = {8{avsByteenable[b] &&
                                           avsAddress == sysc_pkg::ADDR_HI}};
        end
    endgenerate
    assign wdata64 = {avsWritedata, avsWritedata};

    // writable bits only; reserved and read-only bits keep their value
    assign cfg_next = doWrite ? ((cfg_reg & ~(wmask & sysc_pkg::RW_MASK)) |
                      (wdata64 & wmask & sysc_pkg::RW_MASK)) : cfg_reg;

    // wide status is folded into the register, so link and bus agree
    assign wideBits = ({63'h0, lnk.io1Wide} << sysc_pkg::IO1_WIDE_BIT) |
        ({63'h0, lnk.io0Wide} << sysc_pkg::IO0_WIDE_BIT);
    assign readWord = cfg_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_reg <= sysc_pkg::RESET_VAL;
        end else begin
            cfg_reg <= (cfg_next & sysc_pkg::RW_MASK) | wideBits;
        end
    end

    // bus answer: readdata registered, waitrequest low for one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            ack_reg   <= 1'b0;
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg  <= (avsRead || avsWrite) && !ack_reg;
            wait_reg <= !((avsRead || avsWrite) && !ack_reg);
            if (doRead) begin
                if (avsAddress == sysc_pkg::ADDR_LO) begin
                    rdata_reg <= readWord[31:0];
                end else if (avsAddress == sysc_pkg::ADDR_HI) begin
                    rdata_reg <= readWord[63:32];
                end else if (avsAddress == sysc_pkg::ADDR_STATUS) begin
                    rdata_reg <= {31'h0, lnk.illegalCfg};
                end else begin
                    rdata_reg <= 32'h0000_0000;
                end
            end
        end
    end
    assign avsReaddata    = rdata_reg;
    assign avsWaitrequest = wait_reg;

    // drain interval decode; reserved codes act as disabled
    assign drainCode = cfg_reg[sysc_pkg::DRAIN_LSB +: 3];
    assign drainLen  = (drainCode == 3'h1) ? sysc_pkg::DRAIN_C1 :
                       (drainCode == 3'h2) ? sysc_pkg::DRAIN_C2 :
                       (drainCode == 3'h3) ? sysc_pkg::DRAIN_C3 :
                       (drainCode == 3'h4) ? sysc_pkg::DRAIN_C4 :
                       (drainCode == 3'h5) ? sysc_pkg::DRAIN_C5 :
                       11'h000;

    // drain strobe every drainLen cycles
    always_ff @(posedge clk) begin
        if (srst || drainLen == 11'h000) begin
            drainCnt_reg <= 11'h001;
            drain_reg    <= 1'b0;
        end else begin
            drain_reg    <= drainCnt_reg >= drainLen;
            drainCnt_reg <= (drainCnt_reg >= drainLen) ? 11'h001 :
                            drainCnt_reg + 11'h001;
        end
    end

    assign probeField = cfg_reg[sysc_pkg::PROBE_LSB +: 3];

    // registered decoded controls
    always_ff @(posedge clk) begin
        if (srst) begin
            probe_reg <= 4'h1;
            xdly_reg  <= 3'h2;
            xor_reg   <= 1'b0;
            byp_reg   <= 3'h0;
        end else begin
            probe_reg <= (probeField == sysc_pkg::PROBE_ZERO) ?
                         sysc_pkg::PROBE_FULL : {1'b0, probeField};
            xdly_reg  <= {1'b0, cfg_reg[sysc_pkg::XDLY_LSB +: 2]} +
                         sysc_pkg::XDLY_BASE;
            xor_reg   <= cfg_reg[sysc_pkg::XOR_DIS_BIT];
            byp_reg   <= {cfg_reg[sysc_pkg::BYP3_BIT],
                          cfg_reg[sysc_pkg::BYP2_BIT],
                          cfg_reg[sysc_pkg::BYP1_BIT]};
        end
    end

    assign lnk.cfgWord     = cfg_reg;
    assign lnk.probeLimit  = probe_reg;
    assign lnk.drainPulse  = drain_reg;
    assign lnk.extractFill = cfg_reg[sysc_pkg::EFT_BIT];
    assign lnk.fillExtract = cfg_reg[sysc_pkg::FET_LSB +: 2];
    assign lnk.extractDly  = xdly_reg;
    assign memXorDisable   = xor_reg;
    assign bypassDisable   = byp_reg;
endmodule

// file: sysc_pkg.sv
package sysc_pkg;
    // field positions within the 64-bit configuration word
    localparam int IO1_WIDE_BIT = 61;
    localparam int IO0_WIDE_BIT = 60;
    localparam int PROBE_LSB    = 56;
    localparam int REQ_LSB      = 52;
    localparam int XFER_LSB     = 48;
    localparam int ADV_LSB      = 44;
    localparam int TRUE_LSB     = 40;
    localparam int XOR_DIS_BIT  = 39;
    localparam int PAD_LSB      = 36;
    localparam int BYP3_BIT     = 35;
    localparam int BYP2_BIT     = 34;
    localparam int BYP1_BIT     = 33;
    localparam int THROT_BIT    = 32;
    localparam int EFT_BIT      = 31;
    localparam int DRAIN_LSB    = 28;
    localparam int FET_LSB      = 26;
    localparam int XDLY_LSB     = 4;
    // writable bits of the word; reserved and read-only bits are zero
    localparam logic [63:0] RW_MASK   = 64'h0777_77FF_FC00_0030;
    // reset image of the writable and reported fields
    localparam logic [63:0] RESET_VAL = 64'h3121_1110_8800_0000;
    // avalon register offsets (word index)
    localparam logic [1:0] ADDR_LO     = 2'h0;
    localparam logic [1:0] ADDR_HI     = 2'h1;
    localparam logic [1:0] ADDR_STATUS = 2'h2;
    // drain interval codes in cycles
    localparam logic [10:0] DRAIN_C1 = 11'h400;
    localparam logic [10:0] DRAIN_C2 = 11'h100;
    localparam logic [10:0] DRAIN_C3 = 11'h040;
    localparam logic [10:0] DRAIN_C4 = 11'h010;
    localparam logic [10:0] DRAIN_C5 = 11'h001;
    localparam logic [2:0] PROBE_ZERO = 3'h0;
    localparam logic [3:0] PROBE_FULL = 4'h8;
    localparam logic [2:0] XDLY_BASE  = 3'h2;
    localparam logic [1:0] FET_RSVD   = 2'h3;
endpackage

// file: sysc_if.sv
`timescale 1ns/1ns
interface sysc_if;
    logic [63:0] cfgWord;     // configuration image driven by the device
    logic [3:0]  probeLimit;  // decoded probe queue entries, 1..8
    logic        drainPulse;  // one-cycle queue drain strobe
    logic [1:0]  fillExtract; // fill-to-extract turnaround cycles - 1
    logic        extractFill; // extract-to-fill dead cycle
    logic [2:0]  extractDly;  // extract delay in cycles
    logic        io1Wide;     // wide strap of bus 1, from far end
    logic        io0Wide;     // wide strap of bus 0, from far end
    logic        illegalCfg;  // far end flags forbidden settings
    modport device (output cfgWord, probeLimit, drainPulse, fillExtract,
                    extractFill, extractDly, input io1Wide, io0Wide,
                    illegalCfg);
    modport partner (input cfgWord, probeLimit, drainPulse, fillExtract,
                     extractFill, extractDly, output io1Wide, io0Wide,
                     illegalCfg);
endinterface

// file: sysc_partner.sv
`timescale 1ns/1ns
module sysc_partner #(
    parameter logic BUS1_WIDE = 1'b1,
    parameter logic BUS0_WIDE = 1'b1
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // link to device
    sysc_if.partner   lnk,
    // bridge revision, slice count and queue limit straps
    input  wire logic firstRev,
    input  wire logic twoSlices,
    input  wire logic [2:0] bridgeQueueLimit,
    // user side
    output logic      cfgError
);
    logic       err_reg;
    logic       w1_reg;
    logic       w0_reg;
    logic       bad;
    logic [2:0] req;
    logic [2:0] xfr;
    logic [2:0] adv;
    logic [2:0] tru;
    logic [2:0] pad;
    logic [1:0] fill_extract_turnaround;

    assign req = lnk.cfgWord[sysc_pkg::REQ_LSB +: 3];
    assign xfr = lnk.cfgWord[sysc_pkg::XFER_LSB +: 3];
    assign adv = lnk.cfgWord[sysc_pkg::ADV_LSB +: 3];
    assign tru = lnk.cfgWord[sysc_pkg::TRUE_LSB +: 3];
    assign pad = lnk.cfgWord[sysc_pkg::PAD_LSB +: 3];
    assign fill_extract_turnaround = lnk.fillExtract;

    // any forbidden combination; zero codes mean eight, so counted as such
    assign bad = (req == 3'h1) ||
        (firstRev && (req == 3'h0 || req > 3'h4)) ||
        (firstRev && (xfr == 3'h0 || xfr > 3'h2)) ||
        (adv != bridgeQueueLimit) ||
        (firstRev && (adv == 3'h0 || adv > 3'h4)) ||
        (tru != bridgeQueueLimit) ||
        (twoSlices ? (pad != 3'h4) : (pad != 3'h0)) ||
        (lnk.probeLimit == 4'h1 &&
         !lnk.cfgWord[sysc_pkg::THROT_BIT]) ||
        (fill_extract_turnaround == sysc_pkg::FET_RSVD) ||
        (fill_extract_turnaround == 2'h0 && lnk.extractDly > 3'h3) ||
        (fill_extract_turnaround != 2'h0 && lnk.extractDly < 3'h3);

    always_ff @(posedge clk) begin
        if (srst) begin
            err_reg <= 1'b0;
            // straps report from reset on, so no false narrow bus is seen
            w1_reg  <= BUS1_WIDE;
            w0_reg  <= BUS0_WIDE;
        end else begin
            err_reg <= bad;
            w1_reg  <= BUS1_WIDE;
            w0_reg  <= BUS0_WIDE;
        end
    end
    assign lnk.illegalCfg = err_reg;
    assign lnk.io1Wide    = w1_reg;
    assign lnk.io0Wide    = w0_reg;
    assign cfgError       = err_reg;
endmodule

// file: sysc_link_monitor.sv
`timescale 1ns/1ns
// watches the link; registered decodes lag the word by up to two edges
module sysc_link_monitor (
    // clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // link signals
    input wire logic [63:0] cfgWord,
    input wire logic [3:0]  probeLimit,
    input wire logic        drainPulse,
    input wire logic [1:0]  fillExtract,
    input wire logic        extractFill,
    input wire logic [2:0]  extractDly,
    input wire logic        io1Wide,
    input wire logic        io0Wide,
    input wire logic        illegalCfg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // field decodes once the word has held still
    chk_probe_decode: assert property ($stable(cfgWord)[*2] |->
        probeLimit == (cfgWord[58:56] == 3'h0 ? 4'h8 : cfgWord[58:56]))
        else $error("probe limit decode wrong");
    chk_delay_decode: assert property ($stable(cfgWord)[*2] |->
        extractDly == {1'b0, cfgWord[5:4]} + 3'h2)
        else $error("extract delay decode wrong");
    chk_turn_fields: assert property ($stable(cfgWord)[*2] |->
        fillExtract == cfgWord[27:26] && extractFill == cfgWord[31])
        else $error("turnaround fields wrong");
    chk_reserved_zero: assert property ((cfgWord & ~(sysc_pkg::RW_MASK |
        64'h3000_0000_0000_0000)) == 64'h0)
        else $error("reserved bit set");
    chk_wide_report: assert property ($stable({io1Wide, io0Wide})[*2] |->
        cfgWord[61:60] == {io1Wide, io0Wide})
        else $error("wide bus bits wrong");
    // drain strobe: silent when off or reserved, periodic at codes 4 and 5
    chk_drain_idle: assert property ((cfgWord[30:28] == 3'h0 ||
        cfgWord[30:28] > 3'h5)[*2] |-> !drainPulse)
        else $error("drain strobe while disabled");
    chk_drain_every: assert property ((cfgWord[30:28] == 3'h5)[*3]
        |-> drainPulse) else $error("drain strobe missing at code 5");
    chk_drain_sixteen: assert property (drainPulse &&
        cfgWord[30:28] == 3'h4 ##1 (cfgWord[30:28] == 3'h4)[*8]
        ##1 (cfgWord[30:28] == 3'h4)[*8] |-> drainPulse)
        else $error("drain period 16 wrong");
    // forbidden settings reach the far end's flag
    chk_credit_flag: assert property ((cfgWord[54:52] == 3'h1)[*3]
        |-> illegalCfg) else $error("credit 1 not flagged");
    chk_throttle_flag: assert property ((cfgWord[58:56] == 3'h1 &&
        !cfgWord[32])[*3] |-> illegalCfg)
        else $error("probe 1 without throttle not flagged");
endmodule

// file: system_config_register_upper_bench.sv
`timescale 1ns/1ns
`define CHECK(nm, ex, got) begin comparisons++; \
    if ((got) !== (ex)) begin errors++; \
    $display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end
module system_config_register_upper_bench;
    logic        clk = 1'b0, srst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0;
    logic [1:0]  avsAddress = 2'h0;
    logic [31:0] avsWritedata = 32'h0, avsReaddata, rd, hi, lo, w;
    logic [3:0]  avsByteenable = 4'hF, be;
    logic        avsWaitrequest, memXorDisable, cfgError;
    logic        firstRev = 1'b0, twoSlices = 1'b0;
    logic [2:0]  bypassDisable, bridgeQueueLimit = 3'h1;
    int          errors, comparisons, cycles, n;
    int          dexp[8] = '{0, 1, 4, 16, 64, 1024, 0, 0};
    sysc_if lnk ();
    sysc_device i_sysc_device (.clk(clk), .srst(srst), .lnk(lnk.device),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
        .memXorDisable(memXorDisable), .bypassDisable(bypassDisable));
    sysc_partner i_sysc_partner (.clk(clk), .srst(srst),
        .lnk(lnk.partner), .firstRev(firstRev), .twoSlices(twoSlices),
        .bridgeQueueLimit(bridgeQueueLimit), .cfgError(cfgError));
    sysc_link_monitor i_sysc_link_monitor (.clk(clk), .srst(srst),
        .cfgWord(lnk.cfgWord), .probeLimit(lnk.probeLimit),
        .drainPulse(lnk.drainPulse), .fillExtract(lnk.fillExtract),
        .extractFill(lnk.extractFill), .extractDly(lnk.extractDly),
        .io1Wide(lnk.io1Wide), .io0Wide(lnk.io0Wide),
        .illegalCfg(lnk.illegalCfg));
    always #10 clk = ~clk;
    // hang guard: all tests need well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            tally_and_finish();
        end
    end
    // one avalon access; request held until waitrequest is seen low
    task automatic bus(input logic [1:0] a, input logic wr,
                       input logic [31:0] d, input logic [3:0] b);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWritedata <= d;
        avsByteenable <= b;
        do @(posedge clk); while (avsWaitrequest !== 1'b0);
        rd = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        // idle edge: no strobe is driven twice in one time step
        @(posedge clk);
    endtask
    function automatic logic [31:0] merge(logic [31:0] o, d, logic [3:0] b);
        for (int i = 0; i < 4; i++) if (b[i]) o[8*i +: 8] = d[8*i +: 8];
        return o;
    endfunction
    function automatic int ent(logic [2:0] c);
        return (c == 3'h0) ? 8 : int'(c);
    endfunction
    // forbidden settings as the far end judges them
    function automatic logic bad(logic [31:0] h, l);
        logic [1:0] t;
        t = l[27:26];
        return (h[26:24] == 3'h1 && !h[0]) || h[22:20] == 3'h1 ||
            (firstRev && (ent(h[22:20]) > 4 || ent(h[18:16]) > 2 ||
            ent(h[14:12]) > 4)) || h[14:12] != bridgeQueueLimit ||
            h[10:8] != bridgeQueueLimit || h[6:4] != (twoSlices ? 4 : 0) ||
            t == 2'h3 || (t == 2'h0 ? l[5:4] > 2'h1 : l[5:4] == 2'h0);
    endfunction
    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hF2DE));
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        bus(2'h1, 1'b0, 32'h0, 4'hF);
        `CHECK("hi reset", 32'h3121_1110, rd)
        bus(2'h0, 1'b0, 32'h0, 4'hF);
        `CHECK("lo reset", 32'h8800_0000, rd)
        bus(2'h3, 1'b1, 32'hFFFF_FFFF, 4'hF);
        bus(2'h3, 1'b0, 32'h0, 4'hF);
        `CHECK("unmapped", 32'h0, rd)
        $display("reset and unmapped test done");
        hi = 32'h0121_1110;
        lo = 32'h8800_0000;
        // random halves and byte enables, all ones and zeros first
        for (int i = 0; i < 40; i++) begin
            w = (i < 2) ? {32{i[0]}} : $urandom;
            be = (i < 2) ? 4'hF : 4'($urandom);
            bus(2'(i % 2), 1'b1, w, be);
            if (i % 2) hi = merge(hi, w, be);
            else lo = merge(lo, w, be);
            bus(2'(i % 2), 1'b0, 32'h0, 4'hF);
            `CHECK("readback", (i % 2) ? (hi & 32'h0777_77FF) |
                32'h3000_0000 : lo & 32'hFC00_0030, rd)
            `CHECK("probe", 4'(ent(hi[26:24])), lnk.probeLimit)
            `CHECK("xor", hi[7], memXorDisable)
            `CHECK("bypass", hi[3:1], bypassDisable)
            `CHECK("xdly", {1'b0, lo[5:4]} + 3'h2, lnk.extractDly)
            `CHECK("fet", lo[27:26], lnk.fillExtract)
            `CHECK("eft", lo[31], lnk.extractFill)
        end
        $display("field test done");
        // far end judges legal and forbidden settings
        for (int i = 0; i < 40; i++) begin
            firstRev <= 1'($urandom);
            twoSlices <= 1'($urandom);
            bridgeQueueLimit <= 3'($urandom);
            @(posedge clk);
            hi = (i % 2) ? $urandom & 32'h077F_77FF : {8'h02, 8'h21, 1'b0,
                bridgeQueueLimit, 1'b0, bridgeQueueLimit, 1'b0,
                twoSlices ? 3'h4 : 3'h0, 4'h0};
            lo = (i % 4 == 1) ? $urandom & 32'hFC00_0030 : 32'h8400_0010;
            bus(2'h1, 1'b1, hi, 4'hF);
            bus(2'h0, 1'b1, lo, 4'hF);
            // decoded delay lags the word by one edge, the far end's flag by two edges
            repeat (2) @(posedge clk);
            bus(2'h2, 1'b0, 32'h0, 4'hF);
            `CHECK("status", {31'h0, bad(hi, lo)}, rd)
            `CHECK("cfgError", bad(hi, lo), cfgError)
        end
        $display("far end test done");
        // drain strobes counted over one settled 1024-cycle window
        for (int c = 0; c < 8; c++) begin
            bus(2'h0, 1'b1, 32'h8400_0010 | (c << 28), 4'hF);
            repeat (1024) @(posedge clk);
            n = 0;
            repeat (1024) @(posedge clk) n += int'(lnk.drainPulse === 1'b1);
            `CHECK("drains", dexp[c], n)
        end
        $display("drain test done");
        tally_and_finish();
    end
endmodule
